/* File: src/cfg_port_pkg.sv */
// Constants for the serial configuration port
package cfg_port_pkg;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 4;
   localparam int NUM_REGS = 16;
   localparam int CTRL_RW_BIT = 7;
   localparam int CNT_W = 4;
   localparam logic [3:0] CTRL_BITS = 4'h8;
   localparam logic [3:0] FRAME_BITS = 4'h0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Mode register 0 fields
   localparam logic [3:0] MODE_ADDR = 4'h0;
   localparam int ORDER_BIT = 6;
   localparam int SWRST_BIT = 5;
   localparam int INTERP_PD_BIT = 4;
   localparam int IDAC_PD_BIT = 3;
   localparam int QDAC_PD_BIT = 2;
endpackage

/* File: src/dac_config_serial_port.sv */
// Serial configuration port with its register file and power-down decode
`timescale 1ns/1ps

// Operation
// - Chip select low: sample serial input on each serial clock rising edge.
// - Chip select high: ignore serial input, serial output not driven.
// - Cycle is one control byte then one data byte.
// - Control bits 3..0 address the targeted register.
// - Control bit 7: zero writes, one reads.
// - Write data comes on input; read data driven on output.
// - After reset bytes move most significant bit first.
// - Least-bit-leading order shifts both bytes low bit first.
// - Input and output may be tied as one line or kept apart.
// - Port keeps working in every power-down state.
// - Both converters powered down also powers down interpolators.
module dac_config_serial_port #(
   parameter int NREG = cfg_port_pkg::NUM_REGS
) (
   input wire logic clk_sys_in, // System clock, 50 MHz
   input wire logic rstn_in, // Async reset, active low
   input wire logic csn_in, // Chip select, active low
   input wire logic sclk_in, // Serial clock from host
   input wire logic sdi_in, // Serial data input
   output logic sdo_out, // Serial data output
   output logic sdo_oe_out, // Serial output enable
   output logic least_bit_leading_order_out, // Low bit first mode
   output logic interp_pd_out, // Interpolators powered down
   output logic idac_pd_out, // I converter power-down
   output logic qdac_pd_out, // Q converter power-down
   output logic [cfg_port_pkg::BYTE_W*NREG-1:0] regs_out // All registers
);
   import cfg_port_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] cs_sync_q;
   logic [2:0] sck_sync_q;
   logic [2:0] sdi_sync_q;
   logic cs_act_q;
   logic sck_lvl_q;
   logic sdi_lvl_q;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cs_sync_q <= 3'h7;
         sck_sync_q <= 3'h0;
         sdi_sync_q <= 3'h0;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], csn_in};
         sck_sync_q <= {sck_sync_q[1:0], sclk_in};
         sdi_sync_q <= {sdi_sync_q[1:0], sdi_in};
      end
   end

   // A change counts only once stages two and three agree
   wire cs_agree = (cs_sync_q[1] == cs_sync_q[2]);
   wire sck_agree = (sck_sync_q[1] == sck_sync_q[2]);
   wire sdi_agree = (sdi_sync_q[1] == sdi_sync_q[2]);
   wire cs_act_d = cs_agree ? ~cs_sync_q[2] : cs_act_q;
   wire sck_lvl_d = sck_agree ? sck_sync_q[2] : sck_lvl_q;
   wire sdi_lvl_d = sdi_agree ? sdi_sync_q[2] : sdi_lvl_q;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cs_act_q <= 1'b0;
         sck_lvl_q <= 1'b0;
         sdi_lvl_q <= 1'b0;
      end else begin
         cs_act_q <= cs_act_d;
         sck_lvl_q <= sck_lvl_d;
         sdi_lvl_q <= sdi_lvl_d;
      end
   end

   wire sck_rise = cs_act_q & ~sck_lvl_q & sck_lvl_d;
   wire sck_fall = cs_act_q & sck_lvl_q & ~sck_lvl_d;

   // ****************************************
   // Frame sequencer
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CTRL = 4'b0010,
      ST_DATA = 4'b0100,
      ST_DONE = 4'b1000
   } phase_t;

   phase_t phase_q, phase_d;
   logic [CNT_W-1:0] bit_cnt_q;
   logic [BYTE_W-1:0] shift_q;
   logic [BYTE_W-1:0] tx_q;
   logic [ADDR_W-1:0] addr_q;
   logic rd_q;
   logic [BYTE_W-1:0] regs_q [NREG];
   logic sdo_q;
   logic sdo_oe_q;

   wire lsb_first = regs_q[MODE_ADDR][ORDER_BIT];
   // Bit arrives at the top for lsb-first, at the bottom for msb-first
   wire [BYTE_W-1:0] shift_nx = lsb_first ?
      {sdi_lvl_q, shift_q[BYTE_W-1:1]} :
      {shift_q[BYTE_W-2:0], sdi_lvl_q};
   wire byte_done = sck_rise && (bit_cnt_q == CNT_W'(BYTE_W - 1));
   wire [ADDR_W-1:0] ctrl_addr = shift_nx[ADDR_W-1:0];
   wire ctrl_rd = shift_nx[CTRL_RW_BIT];
   wire wr_commit = (phase_q == ST_DATA) && byte_done && !rd_q;
   wire [BYTE_W-1:0] rd_word = regs_q[ctrl_addr];
   wire swrst = wr_commit && (addr_q == MODE_ADDR) && shift_nx[SWRST_BIT];

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         ST_IDLE: if (cs_act_q) phase_d = ST_CTRL;
         ST_CTRL: if (byte_done) phase_d = ST_DATA;
         ST_DATA: if (byte_done) phase_d = ST_DONE;
         // Extra clocks after the data byte are ignored until deselect
         ST_DONE: phase_d = ST_DONE;
         default: phase_d = ST_IDLE;
      endcase
      if (!cs_act_q) phase_d = ST_IDLE;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         phase_q <= ST_IDLE;
         bit_cnt_q <= FRAME_BITS;
         shift_q <= REG_RESET;
         addr_q <= MODE_ADDR;
         rd_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         if (!cs_act_q || phase_q == ST_IDLE || phase_q == ST_DONE) begin
            bit_cnt_q <= FRAME_BITS;
         end else if (sck_rise) begin
            bit_cnt_q <= byte_done ? FRAME_BITS : bit_cnt_q + CNT_W'(1);
            shift_q <= shift_nx;
         end
         if (phase_q == ST_CTRL && byte_done) begin
            addr_q <= ctrl_addr;
            rd_q <= ctrl_rd;
         end
      end
   end

   // ****************************************
   // Read shifter, changes on falling edges
   // ****************************************
   wire tx_load = (phase_q == ST_CTRL) && byte_done && ctrl_rd;
   wire tx_bit = lsb_first ? tx_q[0] : tx_q[BYTE_W-1];
   wire [BYTE_W-1:0] tx_nx = lsb_first ?
      {1'b0, tx_q[BYTE_W-1:1]} : {tx_q[BYTE_W-2:0], 1'b0};
   wire drive_d = cs_act_q && (phase_q == ST_DATA) && rd_q;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_q <= REG_RESET;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_q <= rd_word;
         end else if (drive_d && sck_fall) begin
            sdo_q <= tx_bit;
            tx_q <= tx_nx;
         end
         sdo_oe_q <= drive_d && (sck_fall || sdo_oe_q);
      end
   end

   // ****************************************
   // Register file, always live
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         always_ff @(posedge clk_sys_in or negedge rstn_in) begin
            if (!rstn_in) begin
               regs_q[gi] <= REG_RESET;
            end else if (swrst) begin
               regs_q[gi] <= REG_RESET;
            end else if (wr_commit && addr_q == ADDR_W'(gi)) begin
               regs_q[gi] <= shift_nx;
            end
         end
         assign regs_out[gi*BYTE_W +: BYTE_W] = regs_q[gi];
      end
   endgenerate

   logic interp_pd_q;
   wire both_pd = regs_q[MODE_ADDR][IDAC_PD_BIT] &
                  regs_q[MODE_ADDR][QDAC_PD_BIT];

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         interp_pd_q <= 1'b0;
      end else begin
         interp_pd_q <= regs_q[MODE_ADDR][INTERP_PD_BIT] | both_pd;
      end
   end

   assign sdo_out = sdo_q;
   assign sdo_oe_out = sdo_oe_q;
   assign least_bit_leading_order_out = lsb_first;
   assign interp_pd_out = interp_pd_q;
   assign idac_pd_out = regs_q[MODE_ADDR][IDAC_PD_BIT];
   assign qdac_pd_out = regs_q[MODE_ADDR][QDAC_PD_BIT];

   // ****************************************
   // Checks
   // ****************************************
   a_deselect_quiet: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) !cs_act_q |=> !sdo_oe_out)
      else $error("output driven while deselected");
   a_ctrl_latch: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) (phase_q == ST_CTRL && byte_done)
      |=> addr_q == $past(ctrl_addr))
      else $error("address not latched");
   a_write_store: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) (wr_commit && !swrst)
      |=> regs_q[$past(addr_q)] == $past(shift_nx))
      else $error("write not stored");
   a_read_no_write: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) (phase_q == ST_DATA && rd_q) |-> !wr_commit)
      else $error("read cycle wrote");
   a_sample_rise: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in)
      (sck_rise && (phase_q == ST_CTRL || phase_q == ST_DATA))
      |=> shift_q == $past(shift_nx))
      else $error("bit not sampled");
   a_interp_pd: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) both_pd |=> interp_pd_out)
      else $error("interpolator not powered down");
   a_drive_fall: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) $changed(sdo_out) |-> $past(sck_fall))
      else $error("output changed off falling edge");
   // Newest bit lands at the top in low-bit-first order, at the bottom else
   a_order_shift: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in)
      (sck_rise && (phase_q == ST_CTRL || phase_q == ST_DATA))
      |=> ($past(lsb_first) ? shift_q[BYTE_W-1] : shift_q[0])
      == $past(sdi_lvl_q))
      else $error("bit shifted in wrong order");
   a_two_bytes: assert property (@(posedge clk_sys_in)
      disable iff (!rstn_in) (phase_q == ST_DATA && byte_done)
      |=> phase_q == ST_DONE)
      else $error("frame longer than two bytes");
   c_write: cover property (@(posedge clk_sys_in) wr_commit);
   c_read: cover property (@(posedge clk_sys_in) tx_load);
   c_lsb_write: cover property (@(posedge clk_sys_in) wr_commit && lsb_first);
   c_swrst: cover property (@(posedge clk_sys_in) swrst);
endmodule

/* File: test/cfg_host_model.sv */
// Host-side serial master model for the configuration port
`timescale 1ns/1ps
module cfg_host_model (
   input wire logic clk_in, // Bench clock
   input wire logic miso_in, // Data line as the host sees it
   output logic csn_out, // Chip select, active low
   output logic sclk_out, // Serial clock
   output logic sdi_out // Host data onto the line
);
   logic drv, bit_q, tog_q;
   initial begin
      csn_out = 1'b1;
      sclk_out = 1'b0;
      drv = 1'b0;
      bit_q = 1'b0;
      tog_q = 1'b0;
   end
   // Released line shows a changing pattern, never the last bit
   always @(negedge clk_in) tog_q <= ~tog_q;
   assign sdi_out = drv ? bit_q : tog_q;
   task automatic half();
      repeat (4) @(negedge clk_in);
   endtask
   task automatic xfer(input logic rd, input logic [3:0] adr,
         input logic [7:0] wd, input logic lsb, output logic [7:0] rdv);
      logic [15:0] f;
      int k;
      f = {rd, 3'b000, adr, wd};
      rdv = 8'h00;
      csn_out = 1'b0;
      half();
      for (int i = 0; i < 16; i++) begin
         k = lsb ? (i < 8 ? 8 + i : i - 8) : 15 - i;
         bit_q = f[k];
         drv = !(rd && i >= 8);
         half();
         sclk_out = 1'b1;
         half();
         // Sample late in the high phase, data holds until the fall
         if (i >= 8) rdv[k] = miso_in;
         sclk_out = 1'b0;
      end
      drv = 1'b0;
      half();
      csn_out = 1'b1;
      half();
      half();
   endtask
   task automatic stray(input logic v);
      bit_q = v;
      drv = 1'b1;
      repeat (16) begin
         half();
         sclk_out = 1'b1;
         half();
         sclk_out = 1'b0;
      end
      drv = 1'b0;
   endtask
endmodule

/* File: test/tb_dac_config_serial_port.sv */
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
module tb_dac_config_serial_port;
   import cfg_port_pkg::*;
   logic clk, rstn, csn, sclk, hsdi, sdo, oe, lbo, ipd, ipdq, qpd;
   logic [BYTE_W*NUM_REGS-1:0] regs, exp_r;
   logic [7:0] rd;
   wire logic dline;
   int n_errors = 0;
   int tests_run = 0;
   assign dline = oe ? sdo : hsdi;
   initial clk = 1'b0;
   always #10 clk = ~clk;
   dac_config_serial_port i_dut (.clk_sys_in(clk), .rstn_in(rstn),
      .csn_in(csn), .sclk_in(sclk), .sdi_in(dline), .sdo_out(sdo),
      .sdo_oe_out(oe), .least_bit_leading_order_out(lbo),
      .interp_pd_out(ipd), .idac_pd_out(ipdq), .qdac_pd_out(qpd),
      .regs_out(regs));
   cfg_host_model i_host (.clk_in(clk), .miso_in(dline),
      .csn_out(csn), .sclk_out(sclk), .sdi_out(hsdi));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
         input logic lsb);
      i_host.xfer(1'b0, a, d, lsb, rd);
      exp_r[8*a+:8] = d;
      if (a == MODE_ADDR && d[SWRST_BIT]) exp_r = '0;
   endtask
   task automatic rdv(input logic [3:0] a, input logic lsb);
      i_host.xfer(1'b1, a, 8'h00, lsb, rd);
   endtask
   task automatic sc_reset();
      chk(regs, '0);
      chk({lbo, ipd, ipdq, qpd, oe}, 5'h00);
   endtask
   task automatic sc_rw();
      for (int a = 1; a < 16; a++) begin
         wr(4'(a), {4'(a), ~4'(a)}, 1'b0);
         rdv(4'(a), 1'b0);
         chk(rd, {4'(a), ~4'(a)});
         chk(regs, exp_r);
         chk(oe, 1'b0);
      end
   endtask
   task automatic sc_pd();
      wr(MODE_ADDR, 8'h0C, 1'b0);
      chk({ipd, ipdq, qpd}, 3'b111);
      rdv(MODE_ADDR, 1'b0);
      chk(rd, 8'h0C);
      wr(MODE_ADDR, 8'h08, 1'b0);
      chk({ipd, ipdq, qpd}, 3'b010);
   endtask
   task automatic sc_stray();
      i_host.stray(1'b1);
      chk(regs, exp_r);
      chk(oe, 1'b0);
   endtask
   task automatic sc_lsb();
      wr(MODE_ADDR, 8'h40, 1'b0);
      chk(lbo, 1'b1);
      wr(4'h3, 8'hA5, 1'b1);
      wr(4'h9, 8'h01, 1'b1);
      chk(regs, exp_r);
      rdv(4'h9, 1'b1);
      chk(rd, 8'h01);
      wr(MODE_ADDR, 8'h20, 1'b1);
      chk(regs, '0);
      chk(lbo, 1'b0);
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_errors++;
      wrap_up();
   end
   initial begin
      rstn = 1'b0;
      exp_r = '0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      sc_reset();
      sc_rw();
      sc_pd();
      sc_stray();
      sc_lsb();
      wrap_up();
   end
endmodule
